//--- inc/adder_pkg.sv
// Function
// - code 400 adds two 16-bit words
// - code 401 adds two 32-bit word pairs
// - code 402 adds 16-bit words plus carry
// - code 403 adds 32-bit pairs plus carry
// - operands and results are two's-complement signed
// - low word holds low half, next high
// - zero flag set when stored result zero
// - carry flag set on carry out of msb
// - single add: positives giving 8000-FFFF flag overflow
// - double add: positives giving negative flag overflow
// - single add: negatives giving 0000-7FFF flag underflow
// - double add: negatives giving nonnegative flag underflow
// - with carry: overflow test uses full sum
// - with carry: underflow test uses full sum
// - sign flag copies result msb
// - code 041 forces carry bit to zero
// - plain mode executes every cycle condition true
// - up mode executes only on rising condition
package adder_pkg;
	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [4:0]  OFS_FIRST   = 5'h00;
	localparam logic [4:0]  OFS_SECOND  = 5'h04;
	localparam logic [4:0]  OFS_CONTROL = 5'h08;
	localparam logic [4:0]  OFS_RESULT  = 5'h0C;
	localparam logic [4:0]  OFS_FLAGS   = 5'h10;
	localparam logic [4:0]  OFS_COUNT   = 5'h14;
	// ************************************************************
	// control fields
	// ************************************************************
	localparam int          CODE_LSB    = 0;
	localparam int          CODE_W      = 10;
	localparam int          EXEC_BIT    = 16;
	localparam int          UP_BIT      = 17;
	localparam logic [31:0] CONTROL_MASK = 32'h0003_03FF;
	// ************************************************************
	// flag bit positions
	// ************************************************************
	localparam int          ZERO_BIT    = 0;
	localparam int          CARRY_BIT   = 1;
	localparam int          POS_BIT     = 2;
	localparam int          NEG_BIT     = 3;
	localparam int          SIGN_BIT    = 4;
	localparam int          FAULT_BIT   = 5;
	// ************************************************************
	// function codes, decimal as numbered
	// ************************************************************
	localparam logic [9:0]  FN_ADD      = 10'd400;
	localparam logic [9:0]  FN_ADD_L    = 10'd401;
	localparam logic [9:0]  FN_ADC      = 10'd402;
	localparam logic [9:0]  FN_ADC_L    = 10'd403;
	localparam logic [9:0]  FN_CARRY_CLR = 10'd41;
	// ************************************************************
	// reset values and bus answers
	// ************************************************************
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;
	localparam logic [5:0]  RST_FLAGS   = 6'h00;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : adder_pkg

//--- src/signed_binary_adder_flags.sv
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
module signed_binary_adder_flags
	import adder_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// ************************************************************
	// bus write side
	// ************************************************************
	logic        aw_hold_q;
	logic [4:0]  awaddr_q;
	logic        w_hold_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic [31:0] strb_mask;
	logic        do_write;
	logic        wr_first;
	logic        wr_second;
	logic        wr_control;
	logic        wr_mapped;

	// address and data may arrive in either order; each is held until both are in
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready  = !w_hold_q && !bvalid_q;
	assign do_write      = aw_hold_q && w_hold_q && !bvalid_q;
	assign wr_first      = do_write && (awaddr_q == OFS_FIRST);
	assign wr_second     = do_write && (awaddr_q == OFS_SECOND);
	assign wr_control    = do_write && (awaddr_q == OFS_CONTROL);
	assign wr_mapped     = (awaddr_q == OFS_FIRST) || (awaddr_q == OFS_SECOND)
	                    || (awaddr_q == OFS_CONTROL) || (awaddr_q == OFS_RESULT)
	                    || (awaddr_q == OFS_FLAGS) || (awaddr_q == OFS_COUNT);
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	// byte enables widened to a bit mask
	for (genvar i = 0; i < 4; i++) begin : g_strb
		assign strb_mask[8*i +: 8] = {8{wstrb_q[i]}};
	end

	// capture of address, data and the response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			awaddr_q  <= 5'h00;
			w_hold_q  <= 1'b0;
			wdata_q   <= RST_WORD;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// operand and control registers
	// ************************************************************
	logic [31:0] first_q;
	logic [31:0] second_q;
	logic [31:0] control_q;

	// software writes merge under the byte enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			first_q   <= RST_WORD;
			second_q  <= RST_WORD;
			control_q <= RST_WORD;
		end else begin
			if (wr_first) begin
				first_q <= (first_q & ~strb_mask) | (wdata_q & strb_mask);
			end
			if (wr_second) begin
				second_q <= (second_q & ~strb_mask) | (wdata_q & strb_mask);
			end
			if (wr_control) begin
				control_q <= ((control_q & ~strb_mask) | (wdata_q & strb_mask))
				           & CONTROL_MASK;
			end
		end
	end

	// ************************************************************
	// execution condition and firing
	// ************************************************************
	logic [9:0] code;
	logic       exec_cond;
	logic       up_mode;
	logic       exec_prev_q;
	logic       fire;

	assign code      = control_q[CODE_LSB +: CODE_W];
	assign exec_cond = control_q[EXEC_BIT];
	assign up_mode   = control_q[UP_BIT];
	// up mode fires on the rising condition, plain mode on every true cycle
	assign fire      = exec_cond && (!up_mode || !exec_prev_q);

	// last cycle's condition for the rising-edge test
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			exec_prev_q <= 1'b0;
		end else begin
			exec_prev_q <= exec_cond;
		end
	end

	// ************************************************************
	// adder datapath
	// ************************************************************
	logic        is_double;
	logic        with_carry;
	logic        is_add;
	logic        carry_q;
	logic        carry_in;
	logic [16:0] sum_s;
	logic [32:0] sum_d;
	logic [31:0] sum_word;
	logic        sum_cout;
	logic        msb_a;
	logic        msb_b;
	logic        msb_r;

	assign is_add     = (code == FN_ADD) || (code == FN_ADD_L)
	                 || (code == FN_ADC) || (code == FN_ADC_L);
	assign is_double  = (code == FN_ADD_L) || (code == FN_ADC_L);
	assign with_carry = (code == FN_ADC) || (code == FN_ADC_L);
	// the incoming carry joins only the with-carry codes
	assign carry_in   = with_carry && carry_q;
	// low word in bits 15:0, next word in bits 31:16
	assign sum_s      = {1'b0, first_q[15:0]} + {1'b0, second_q[15:0]}
	                  + {16'h0000, carry_in};
	assign sum_d      = {1'b0, first_q} + {1'b0, second_q}
	                  + {32'h0000_0000, carry_in};
	assign sum_word   = is_double ? sum_d[31:0] : {16'h0000, sum_s[15:0]};
	assign sum_cout   = is_double ? sum_d[32] : sum_s[16];
	// sign bits of the operand and result width in use
	assign msb_a      = is_double ? first_q[31] : first_q[15];
	assign msb_b      = is_double ? second_q[31] : second_q[15];
	assign msb_r      = is_double ? sum_d[31] : sum_s[15];

	// ************************************************************
	// result, flags and execution count
	// ************************************************************
	logic [31:0] result_q;
	logic [31:0] count_q;
	logic        zero_q;
	logic        pos_q;
	logic        neg_q;
	logic        sign_q;
	logic        fault_q;
	logic [31:0] flags_word;

	// a fired add stores the sum and renews every flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_q <= RST_WORD;
			count_q  <= RST_WORD;
			{fault_q, sign_q, neg_q, pos_q, carry_q, zero_q} <= RST_FLAGS;
		end else if (fire && is_add) begin
			result_q <= sum_word;
			count_q  <= count_q + 32'h0000_0001;
			zero_q   <= (sum_word == RST_WORD);
			carry_q  <= sum_cout;
			pos_q    <= !msb_a && !msb_b && msb_r;
			neg_q    <= msb_a && msb_b && !msb_r;
			sign_q   <= msb_r;
			fault_q  <= 1'b0;
		end else if (fire && (code == FN_CARRY_CLR)) begin
			carry_q <= 1'b0;
			count_q <= count_q + 32'h0000_0001;
		end
	end

	assign flags_word = {26'h0, fault_q, sign_q, neg_q, pos_q, carry_q, zero_q};

	// ************************************************************
	// bus read side
	// ************************************************************
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [31:0] rd_mux;
	logic        rd_mapped;

	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign rd_mapped     = (s_axi_araddr == OFS_FIRST) || (s_axi_araddr == OFS_SECOND)
	                    || (s_axi_araddr == OFS_CONTROL) || (s_axi_araddr == OFS_RESULT)
	                    || (s_axi_araddr == OFS_FLAGS) || (s_axi_araddr == OFS_COUNT);
	// read selection; unmapped reads return zero
	assign rd_mux = (s_axi_araddr == OFS_FIRST)   ? first_q   :
	                (s_axi_araddr == OFS_SECOND)  ? second_q  :
	                (s_axi_araddr == OFS_CONTROL) ? control_q :
	                (s_axi_araddr == OFS_RESULT)  ? result_q  :
	                (s_axi_araddr == OFS_FLAGS)   ? flags_word :
	                (s_axi_araddr == OFS_COUNT)   ? count_q   : RST_WORD;

	// one read in flight, answered the cycle after it is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= RST_WORD;
			rresp_q  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_mux;
			rresp_q  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	single_sum_a: assert property (fire && code == FN_ADD |=>
		result_q == {16'h0000, $past(first_q[15:0]) + $past(second_q[15:0])})
		else $error("single add result wrong");
	double_sum_a: assert property (fire && code == FN_ADD_L |=>
		result_q == $past(first_q) + $past(second_q))
		else $error("double add result wrong");
	single_carry_a: assert property (fire && code == FN_ADC |=>
		result_q[15:0] == $past(first_q[15:0]) + $past(second_q[15:0])
		+ {15'h0000, $past(carry_q)})
		else $error("single add with carry wrong");
	double_carry_a: assert property (fire && code == FN_ADC_L |=>
		result_q == $past(first_q) + $past(second_q) + {31'h0, $past(carry_q)})
		else $error("double add with carry wrong");
	zero_flag_a: assert property (fire && is_add |=> zero_q == (result_q == 32'h0))
		else $error("zero flag disagrees with result");
	pos_wrap_a: assert property (fire && code == FN_ADD && !first_q[15] && !second_q[15]
		|=> pos_q == result_q[15])
		else $error("positive wrap flag wrong");
	neg_wrap_a: assert property (fire && is_double && first_q[31] && second_q[31]
		|=> neg_q == !result_q[31] && !pos_q)
		else $error("negative wrap flag wrong");
	sign_fault_a: assert property (fire && is_add |=> sign_q == ($past(is_double) ?
		result_q[31] : result_q[15]) && !fault_q)
		else $error("sign or fault flag wrong");
	carry_clear_a: assert property (fire && code == FN_CARRY_CLR |=> !carry_q)
		else $error("carry not cleared");
	up_once_a: assert property (up_mode && fire ##1 up_mode |-> !fire)
		else $error("up mode fired twice");
	plain_every_a: assert property (!up_mode && exec_cond && is_add |=>
		count_q == $past(count_q) + 32'h1)
		else $error("plain mode skipped a cycle");

	// carry and wrap flags judged from the stored result and the operands alone
	carry_single_a: assert property (fire && code == FN_ADD |=>
		carry_q == (result_q[15:0] < $past(first_q[15:0])))
		else $error("single carry flag wrong");
	carry_double_a: assert property (fire && code == FN_ADD_L |=>
		carry_q == (result_q < $past(first_q)))
		else $error("double carry flag wrong");
	pos_wrap_long_a: assert property (fire && is_double && !first_q[31] && !second_q[31]
		|=> pos_q == result_q[31])
		else $error("double positive wrap flag wrong");
	neg_wrap_carry_a: assert property (fire && code == FN_ADC && first_q[15] && second_q[15]
		|=> neg_q == !result_q[15])
		else $error("single negative wrap flag wrong");
endmodule : signed_binary_adder_flags

//--- sim/axi_lite_master.sv
module axi_lite_master (
	input  wire logic        aclk,
	output logic [4:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [4:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus at time zero
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// operands go over as whole words, a pair packed in one word
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] resp);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			// released address and data show the inverse, never the last value
			if (!ad && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (!wd && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
			if (bvalid) begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
		@(posedge aclk);
	endtask : wr
	// read one word, answer taken at the edge that sees rvalid
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] resp);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
			if (rvalid) begin
				d = rdata;
				resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
		@(posedge aclk);
	endtask : rd
endmodule : axi_lite_master

//--- sim/tb.sv
module tb
	import adder_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [9:0]  code;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] res;
		logic [5:0]  flg;
	} row_t;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [4:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	int          mismatches = 0;
	int          checked = 0;
	int          cycles = 0;
	// carry state runs on from row to row, starting clear
	row_t        rows [9] = '{
		'{FN_ADD, 32'hAAAA_7FFF, 32'h5555_0001, 32'h0000_8000, 6'h14},
		'{FN_ADD, 32'h0000_8000, 32'h0000_8000, 32'h0000_0000, 6'h0B},
		'{FN_ADC, 32'h0000_7FFE, 32'h0000_0001, 32'h0000_8000, 6'h14},
		'{FN_ADD_L, 32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_0000, 6'h03},
		'{FN_ADC_L, 32'h7FFF_FFFE, 32'h0000_0001, 32'h8000_0000, 6'h14},
		'{FN_ADD_L, 32'h8000_0000, 32'hFFFF_FFFF, 32'h7FFF_FFFF, 6'h0A},
		'{FN_CARRY_CLR, 32'h0000_0000, 32'h0000_0000, 32'h7FFF_FFFF, 6'h08},
		'{FN_ADC_L, 32'h8000_0000, 32'h8000_0000, 32'h0000_0000, 6'h0B},
		'{FN_ADC, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF, 6'h12}
	};
	always #2.5 aclk = ~aclk;
	signed_binary_adder_flags uut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	axi_lite_master m (
		.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	// ************************************************************
	// compare and report
	// ************************************************************
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task results;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	// hang guard, the run needs well under a thousand cycles
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			results;
		end
	end
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 6; i++) begin
			m.rd(5'(i * 4), d, r);
			chk("reset value", d, 32'h0);
		end
		$display("test reset values done");
		// one up-differentiated execution per row, re-armed by clearing the condition
		foreach (rows[i]) begin
			m.wr(OFS_FIRST, rows[i].a, 4'hF, r);
			m.wr(OFS_SECOND, rows[i].b, 4'hF, r);
			m.wr(OFS_CONTROL, 32'h0003_0000 | 32'(rows[i].code), 4'hF, r);
			m.rd(OFS_RESULT, d, r);
			chk("result", d, rows[i].res);
			m.rd(OFS_FLAGS, d, r);
			chk("flags", d, {26'h0, rows[i].flg});
			m.wr(OFS_CONTROL, 32'h0, 4'hF, r);
		end
		m.rd(OFS_COUNT, d, r);
		chk("up mode count", d, 32'd9);
		$display("test operation table done");
		// plain mode repeats while the condition holds
		m.wr(OFS_CONTROL, 32'h0001_0000 | 32'(FN_ADD), 4'hF, r);
		m.wr(OFS_CONTROL, 32'h0, 4'hF, r);
		m.rd(OFS_COUNT, d, r);
		chk("plain repeats", {31'h0, d > 32'd11}, 32'h1);
		m.rd(OFS_RESULT, d, r);
		chk("plain result", d, 32'h0000_FFFE);
		$display("test plain mode done");
		// byte strobes, reserved control bits, read-only and unmapped places
		m.wr(OFS_FIRST, 32'h1122_3344, 4'hF, r);
		m.wr(OFS_FIRST, 32'hAABB_CCDD, 4'h2, r);
		m.rd(OFS_FIRST, d, r);
		chk("strobe merge", d, 32'h1122_CC44);
		m.wr(OFS_CONTROL, 32'hFFFF_FFFF, 4'hF, r);
		m.rd(OFS_CONTROL, d, r);
		chk("control bits", d, CONTROL_MASK);
		m.wr(OFS_CONTROL, 32'h0, 4'hF, r);
		m.wr(OFS_RESULT, 32'h1234_5678, 4'hF, r);
		chk("read only bresp", 32'(r), 32'(RESP_OKAY));
		m.rd(OFS_RESULT, d, r);
		chk("result read only", d, 32'h0000_FFFE);
		chk("result rresp", 32'(r), 32'(RESP_OKAY));
		m.wr(5'h18, 32'h5A5A_5A5A, 4'hF, r);
		chk("unmapped bresp", 32'(r), 32'(RESP_SLVERR));
		m.rd(5'h18, d, r);
		chk("unmapped rdata", d, 32'h0);
		chk("unmapped rresp", 32'(r), 32'(RESP_SLVERR));
		$display("test bus corners done");
		// reset in mid-run clears flags and count
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		m.rd(OFS_FLAGS, d, r);
		chk("flags after reset", d, 32'h0);
		m.rd(OFS_COUNT, d, r);
		chk("count after reset", d, 32'h0);
		$display("test second reset done");
		results;
	end
endmodule : tb
